// file: core/axis_stop_block.v
// Axis stop command handshake, axis lock and AXI4-Lite register slave
//
// Notes on behaviour
// - Busy rises in the tick seeing trigger rise
// - Active rises one update period after busy
// - At zero speed done, busy, active held
// - Trigger fall after completion clears all three
// - Early trigger fall: done one period then clear
// - Supersession sets flag, drops busy and active
// - Later stop on same axis aborts earlier one
// - Flag clears on trigger low, else one period
// - Fault or illegal input: error, code, drop
// - Axis held stopping while trigger stays high
// - Refuse other motion while busy or done is set
// - Takeover aborts velocity move, clears at-velocity
// - Decelerate at supplied rate until rest
// - Axis 1 to 32, decel rate captured at rise
// - Only rising trigger starts; others ignored
`timescale 1ns/1ps
`include "axis_stop_map.vh"
module axis_stop_block #(
  parameter TICK_CYCLES = `UPDATE_CYCLES,
  parameter SPEED_W     = 16
) (
  input  wire               core_clk_i,
  input  wire               reset_n_i,
  input  wire [5:0]         s_axi_awaddr,
  input  wire               s_axi_awvalid,
  output reg                s_axi_awready,
  input  wire [31:0]        s_axi_wdata,
  input  wire [3:0]         s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output reg                s_axi_wready,
  output reg  [1:0]         s_axi_bresp,
  output reg                s_axi_bvalid,
  input  wire               s_axi_bready,
  input  wire [5:0]         s_axi_araddr,
  input  wire               s_axi_arvalid,
  output reg                s_axi_arready,
  output reg  [31:0]        s_axi_rdata,
  output reg  [1:0]         s_axi_rresp,
  output reg                s_axi_rvalid,
  input  wire               s_axi_rready,
  input  wire               axis_alarm_i,
  input  wire               axis_online_i,
  input  wire               later_stop_i,
  input  wire               other_cmd_i,
  input  wire               vel_move_running_i,
  input  wire [SPEED_W-1:0] axis_speed_i,
  output reg  [SPEED_W-1:0] speed_cmd_o,
  output reg                vel_move_aborted_o,
  output reg                vel_at_speed_clr_o,
  output reg                axis_locked_o,
  output reg                cmd_refused_o,
  output reg                irq_o
);
  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_START = 6'h02;
  localparam [5:0] S_DECEL = 6'h04;
  localparam [5:0] S_HOLD  = 6'h08;
  localparam [5:0] S_LAST  = 6'h10;
  localparam [5:0] S_WAIT  = 6'h20;

  function [31:0] merge_strb;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        merge_strb[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg [4:0]         pin_s1_r;
  reg [4:0]         pin_s2_r;
  reg [SPEED_W-1:0] spd_s1_r;
  reg [SPEED_W-1:0] spd_s2_r;
  wire alarm_s   = pin_s2_r[0];
  wire online_s  = pin_s2_r[1];
  wire later_s   = pin_s2_r[2];
  wire other_s   = pin_s2_r[3];
  wire velrun_s  = pin_s2_r[4];

  // Speed is only snapshotted at takeover, so a two-stage copy is enough
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_s1_r <= 5'h02;
      pin_s2_r <= 5'h02;
      spd_s1_r <= {SPEED_W{1'b0}};
      spd_s2_r <= {SPEED_W{1'b0}};
    end else begin
      pin_s1_r <= {vel_move_running_i, other_cmd_i, later_stop_i, axis_online_i, axis_alarm_i};
      pin_s2_r <= pin_s1_r;
      spd_s1_r <= axis_speed_i;
      spd_s2_r <= spd_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Update tick and speed ramp
  wire               tick;
  wire [SPEED_W-1:0] speed;
  reg                load_r;
  reg  [15:0]        decel_cap_r;

  update_tick #(.DIV(TICK_CYCLES)) u_tick (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .tick_o     (tick)
  );

  reg [5:0] state_r;

  decel_ramp #(.W(SPEED_W)) u_ramp (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .tick_i     (tick),
    .load_i     (load_r),
    .load_val_i (spd_s2_r),
    .run_i      (state_r == S_DECEL),
    .rate_i     (decel_cap_r[SPEED_W-1:0]),
    .speed_o    (speed)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers written by software and handshake status state
  reg [31:0] ctrl_r;
  reg [15:0] decel_r;
  reg [15:0] jerk_r;
  reg [3:0]  irq_mask_r;
  reg [3:0]  irq_stat_r;
  reg        busy_r;
  reg        active_r;
  reg        done_r;
  reg        super_r;
  reg        error_r;
  reg [15:0] fault_code_r;
  reg [5:0]  axis_cap_r;
  reg        trig_prev_r;
  reg        later_prev_r;
  reg        later_seen_r;

  wire       trig    = ctrl_r[`CTRL_TRIG_BIT];
  wire [5:0] axis_in = ctrl_r[`CTRL_AXIS_MSB:`CTRL_AXIS_LSB];
  wire       locked  = busy_r | done_r;

  ////////////////////////////////////////////////////////////////////////////
  // Handshake state machine, evaluated once per update tick
  wire rise  = trig & ~trig_prev_r;
  wire fault = alarm_s | ~online_s;

  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r            <= S_IDLE;
      busy_r             <= 1'b0;
      active_r           <= 1'b0;
      done_r             <= 1'b0;
      super_r            <= 1'b0;
      error_r            <= 1'b0;
      fault_code_r       <= `FC_NONE;
      trig_prev_r        <= 1'b0;
      axis_cap_r         <= 6'h0;
      decel_cap_r        <= 16'h0;
      load_r             <= 1'b0;
      later_prev_r       <= 1'b0;
      later_seen_r       <= 1'b0;
      vel_move_aborted_o <= 1'b0;
      vel_at_speed_clr_o <= 1'b0;
    end else begin
      load_r       <= 1'b0;
      later_prev_r <= later_s;
      // A later stop edge between ticks is kept until the next tick
      if (later_s && !later_prev_r) begin
        later_seen_r <= 1'b1;
      end else if (tick) begin
        later_seen_r <= 1'b0;
      end
      if (tick) begin
        trig_prev_r <= trig;
        case (state_r)
          S_IDLE: begin
            vel_move_aborted_o <= 1'b0;
            vel_at_speed_clr_o <= 1'b0;
            if (rise) begin
              axis_cap_r  <= axis_in;
              decel_cap_r <= decel_r;
              if (axis_in < `AXIS_MIN || axis_in > `AXIS_MAX) begin
                error_r      <= 1'b1;
                fault_code_r <= `FC_BAD_AXIS;
                state_r      <= S_WAIT;
              end else if (decel_r == 16'h0) begin
                error_r      <= 1'b1;
                fault_code_r <= `FC_BAD_DECEL;
                state_r      <= S_WAIT;
              end else if (jerk_r == 16'h0) begin
                error_r      <= 1'b1;
                fault_code_r <= `FC_BAD_JERK;
                state_r      <= S_WAIT;
              end else begin
                busy_r  <= 1'b1;
                state_r <= S_START;
              end
            end
          end
          S_START, S_DECEL, S_HOLD: begin
            if (fault) begin
              error_r      <= 1'b1;
              fault_code_r <= alarm_s ? `FC_ALARM : `FC_OFFLINE;
              busy_r       <= 1'b0;
              active_r     <= 1'b0;
              done_r       <= 1'b0;
              state_r      <= S_WAIT;
            end else if (later_seen_r || (later_s && !later_prev_r)) begin
              super_r  <= 1'b1;
              busy_r   <= 1'b0;
              active_r <= 1'b0;
              done_r   <= 1'b0;
              state_r  <= S_WAIT;
            end else if (state_r == S_START) begin
              active_r <= 1'b1;
              load_r   <= 1'b1;
              if (velrun_s) begin
                vel_move_aborted_o <= 1'b1;
                vel_at_speed_clr_o <= 1'b1;
              end
              state_r <= S_DECEL;
            end else if (state_r == S_DECEL) begin
              if (speed == {SPEED_W{1'b0}} && !load_r) begin
                done_r  <= 1'b1;
                state_r <= trig ? S_HOLD : S_LAST;
              end
            end else if (!trig) begin
              done_r   <= 1'b0;
              busy_r   <= 1'b0;
              active_r <= 1'b0;
              state_r  <= S_IDLE;
            end
          end
          S_LAST: begin
            done_r   <= 1'b0;
            busy_r   <= 1'b0;
            active_r <= 1'b0;
            state_r  <= S_IDLE;
          end
          S_WAIT: begin
            vel_move_aborted_o <= 1'b0;
            vel_at_speed_clr_o <= 1'b0;
            if (!trig) begin
              super_r      <= 1'b0;
              error_r      <= 1'b0;
              fault_code_r <= `FC_NONE;
              state_r      <= S_IDLE;
            end
          end
          default: begin
            state_r <= S_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Axis lock and refusal of other motion commands
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      axis_locked_o <= 1'b0;
      cmd_refused_o <= 1'b0;
      speed_cmd_o   <= {SPEED_W{1'b0}};
    end else begin
      axis_locked_o <= locked;
      cmd_refused_o <= locked & other_s;
      speed_cmd_o   <= speed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events
  reg done_q_r;
  reg super_q_r;
  reg error_q_r;
  reg refuse_q_r;
  wire [3:0] ev = {cmd_refused_o & ~refuse_q_r, error_r & ~error_q_r,
                   super_r & ~super_q_r, done_r & ~done_q_r};

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  reg        aw_have_r;
  reg        w_have_r;
  reg [3:0]  aw_idx_r;
  reg [31:0] wdata_r;
  reg [3:0]  wstrb_r;
  wire [3:0] ar_idx = s_axi_araddr[5:2];
  wire       do_wr  = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire [3:0] w1c    = (do_wr && aw_idx_r == `REG_IRQ_STAT) ? (wdata_r[3:0] & {4{wstrb_r[0]}}) : 4'h0;
  wire [31:0] decel_m = merge_strb({16'h0, decel_r}, wdata_r, wstrb_r);
  wire [31:0] jerk_m  = merge_strb({16'h0, jerk_r}, wdata_r, wstrb_r);

  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_idx_r      <= 4'h0;
      wdata_r       <= 32'h0;
      wstrb_r       <= 4'h0;
      ctrl_r        <= `CTRL_RST;
      decel_r       <= `DECEL_RST;
      jerk_r        <= `JERK_RST;
      irq_mask_r    <= `MASK_RST;
    end else begin
      s_axi_awready <= ~aw_have_r & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_have_r & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_idx_r  <= s_axi_awaddr[5:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        case (aw_idx_r)
          `REG_CTRL:     ctrl_r     <= merge_strb(ctrl_r, wdata_r, wstrb_r) & 32'h0000_3f01;
          `REG_DECEL:    decel_r    <= decel_m[15:0];
          `REG_JERK:     jerk_r     <= jerk_m[15:0];
          `REG_IRQ_MASK: irq_mask_r <= wstrb_r[0] ? wdata_r[3:0] : irq_mask_r;
          `REG_IRQ_STAT: irq_mask_r <= irq_mask_r;
          default:       s_axi_bresp <= `RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Set wins over a write-one clear landing in the same cycle
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_stat_r <= 4'h0;
      irq_o      <= 1'b0;
      done_q_r   <= 1'b0;
      super_q_r  <= 1'b0;
      error_q_r  <= 1'b0;
      refuse_q_r <= 1'b0;
    end else begin
      done_q_r   <= done_r;
      super_q_r  <= super_r;
      error_q_r  <= error_r;
      refuse_q_r <= cmd_refused_o;
      irq_stat_r <= (irq_stat_r & ~w1c) | ev;
      irq_o      <= |(((irq_stat_r & ~w1c) | ev) & irq_mask_r);
    end
  end

  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (ar_idx)
          `REG_CTRL:     s_axi_rdata <= ctrl_r;
          `REG_DECEL:    s_axi_rdata <= {16'h0, decel_r};
          `REG_JERK:     s_axi_rdata <= {16'h0, jerk_r};
          `REG_STATUS:   s_axi_rdata <= {fault_code_r, 2'h0, axis_cap_r, 2'h0, locked, error_r, super_r,
                                         done_r, active_r, busy_r};
          `REG_IRQ_STAT: s_axi_rdata <= {28'h0, irq_stat_r};
          `REG_IRQ_MASK: s_axi_rdata <= {28'h0, irq_mask_r};
          `REG_SPEED:    s_axi_rdata <= {{(32-SPEED_W){1'b0}}, speed};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// file: core/axis_stop_map.vh
// Register map, field positions, fault codes and timing for the axis stop block
`ifndef AXIS_STOP_MAP_VH
`define AXIS_STOP_MAP_VH

// Register word indices; the byte address is four times the index
`define REG_CTRL        4'h0
`define REG_DECEL       4'h1
`define REG_JERK        4'h2
`define REG_STATUS      4'h3
`define REG_IRQ_STAT    4'h4
`define REG_IRQ_MASK    4'h5
`define REG_SPEED       4'h6

// Control fields
`define CTRL_TRIG_BIT   0
`define CTRL_AXIS_LSB   8
`define CTRL_AXIS_MSB   13

// Status fields
`define ST_BUSY_BIT     0
`define ST_ACTIVE_BIT   1
`define ST_DONE_BIT     2
`define ST_SUPER_BIT    3
`define ST_ERROR_BIT    4
`define ST_LOCK_BIT     5
`define ST_CODE_LSB     16

// Interrupt event bits
`define IRQ_DONE_BIT    0
`define IRQ_SUPER_BIT   1
`define IRQ_ERROR_BIT   2
`define IRQ_REFUSE_BIT  3

// Reset values
`define CTRL_RST        32'h0000_0100
`define DECEL_RST       16'h0001
`define JERK_RST        16'h0001
`define MASK_RST        4'h0

// Legal axis numbers
`define AXIS_MIN        6'h01
`define AXIS_MAX        6'h20

// Fault codes, values arbitrary
`define FC_NONE         16'h0000
`define FC_BAD_AXIS     16'h0101
`define FC_BAD_DECEL    16'h0102
`define FC_BAD_JERK     16'h0103
`define FC_ALARM        16'h0201
`define FC_OFFLINE      16'h0202

// Update period and core clock
`define UPDATE_PERIOD_NS 1000000
`define CORE_CLK_HZ      10000000
`define UPDATE_CYCLES    ((`UPDATE_PERIOD_NS / 1000) * (`CORE_CLK_HZ / 1000000))

// Bus answers
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// file: core/update_tick.v
// Divider that produces the one-cycle update period tick
`timescale 1ns/1ps
module update_tick #(
  parameter DIV = 10000
) (
  input  wire        core_clk_i,
  input  wire        reset_n_i,
  output reg         tick_o
);
  reg [31:0] cnt_r;

  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r  <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt_r == DIV - 1) begin
      cnt_r  <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule

// file: core/decel_ramp.v
// Speed ramp that lowers the commanded speed by the rate on each update tick
`timescale 1ns/1ps
module decel_ramp #(
  parameter W = 16
) (
  input  wire         core_clk_i,
  input  wire         reset_n_i,
  input  wire         tick_i,
  input  wire         load_i,
  input  wire [W-1:0] load_val_i,
  input  wire         run_i,
  input  wire [W-1:0] rate_i,
  output reg  [W-1:0] speed_o
);
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      speed_o <= {W{1'b0}};
    end else if (load_i) begin
      speed_o <= load_val_i;
    end else if (tick_i && run_i) begin
      // Clamp at rest so a large rate never wraps round
      if (speed_o > rate_i) begin
        speed_o <= speed_o - rate_i;
      end else begin
        speed_o <= {W{1'b0}};
      end
    end
  end
endmodule

// file: bench/axis_stop_block_monitor.sv
// Port-level concurrent checks for the axis stop block
`timescale 1ns/1ps
module axis_stop_block_monitor #(
  parameter SPEED_W = 16
) (
  input wire               core_clk_i,
  input wire               reset_n_i,
  input wire               s_axi_awready,
  input wire               s_axi_bvalid,
  input wire               s_axi_bready,
  input wire               s_axi_rvalid,
  input wire               s_axi_rready,
  input wire [31:0]        s_axi_rdata,
  input wire [1:0]         s_axi_rresp,
  input wire [SPEED_W-1:0] speed_cmd_o,
  input wire               vel_move_aborted_o,
  input wire               vel_at_speed_clr_o,
  input wire               axis_locked_o,
  input wire               cmd_refused_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////////////////
  AST_AWREADY_PULSE: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready longer than one cycle");
  AST_BVALID_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
  AST_RVALID_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
  AST_RDATA_ERR: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0) else $error("slverr data");
  AST_REFUSE_LOCKED: assert property (cmd_refused_o |-> axis_locked_o) else $error("refusal while free");
  AST_UNLOCK_FREE: assert property ($fell(axis_locked_o) |=> !cmd_refused_o) else $error("refusal after unlock");
  AST_ABORT_PAIR: assert property (vel_move_aborted_o == vel_at_speed_clr_o) else $error("abort pair split");
  AST_ABORT_LOCKED: assert property ($rose(vel_move_aborted_o) |-> axis_locked_o) else $error("abort unlocked");
  // Tick spacing of at least five clocks is assumed by the repetitions, as the ramp load lands one clock after a tick
  AST_LOCK_TICK: assert property ($changed(axis_locked_o) |=> $stable(axis_locked_o) [*3]) else $error("lock off tick");
  AST_SPEED_TICK: assert property ($changed(speed_cmd_o) |=> $stable(speed_cmd_o) [*3]) else $error("speed off tick");
endmodule
bind axis_stop_block axis_stop_block_monitor #(.SPEED_W(SPEED_W)) u_mon (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .speed_cmd_o(speed_cmd_o), .vel_move_aborted_o(vel_move_aborted_o),
  .vel_at_speed_clr_o(vel_at_speed_clr_o), .axis_locked_o(axis_locked_o), .cmd_refused_o(cmd_refused_o));

// file: bench/axis_sim.sv
// Servo axis model: runs a velocity move, then follows the commanded ramp
`timescale 1ns/1ps
module axis_sim #(
  parameter SPEED_W = 16,
  parameter RUN     = 16'h0400
) (
  input  wire               core_clk_i,
  input  wire               reset_n_i,
  input  wire               vel_start_i,
  input  wire               vel_move_aborted_i,
  input  wire [SPEED_W-1:0] speed_cmd_i,
  output reg                vel_running_o,
  output reg  [SPEED_W-1:0] axis_speed_o
);
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vel_running_o <= 1'b0;
      axis_speed_o  <= {SPEED_W{1'b0}};
    end else begin
      if (vel_move_aborted_i)
        vel_running_o <= 1'b0;
      else if (vel_start_i)
        vel_running_o <= 1'b1;
      // Once the stop owns the axis, actual speed tracks the ramp
      axis_speed_o <= vel_running_o ? RUN : speed_cmd_i;
    end
  end
endmodule

// file: bench/axis_stop_block_bench.sv
// Self-checking bench for the axis stop block
`timescale 1ns/1ps
`include "axis_stop_map.vh"
module axis_stop_block_bench;
  localparam [5:0] A_CT = 6'h00, A_DC = 6'h04, A_JK = 6'h08, A_ST = 6'h0c, A_IS = 6'h10, A_IM = 6'h14;
  reg core_clk_i = 1'b0, reset_n_i = 1'b0;
  reg [5:0] awaddr = 6'h00, araddr = 6'h00;
  reg [31:0] wdata = 32'h0, st;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg alarm = 1'b0, online = 1'b1, later = 1'b0, other = 1'b0, vel_start = 1'b0, ab_seen = 1'b0;
  reg [1:0] rr;
  reg [15:0] prev = 16'h0;
  wire awready, wready, bvalid, arready, rvalid, vel_run, ab, atclr, locked, refused, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] speed_cmd, axis_speed;
  integer err_count = 0, n_compared = 0, k;
  always #50 core_clk_i = ~core_clk_i;
  axis_stop_block #(.TICK_CYCLES(8), .SPEED_W(16)) u_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .axis_alarm_i(alarm), .axis_online_i(online), .later_stop_i(later), .other_cmd_i(other),
    .vel_move_running_i(vel_run), .axis_speed_i(axis_speed), .speed_cmd_o(speed_cmd), .vel_move_aborted_o(ab),
    .vel_at_speed_clr_o(atclr), .axis_locked_o(locked), .cmd_refused_o(refused), .irq_o(irq));
  axis_sim u_axis (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .vel_start_i(vel_start),
    .vel_move_aborted_i(ab), .speed_cmd_i(speed_cmd), .vel_running_o(vel_run), .axis_speed_o(axis_speed));
  ////////////////////////////////////////////////////////////////////////////
  task cmp(input [31:0] e, input [31:0] s, input string nm);
    n_compared = n_compared + 1;
    if (s !== e) begin
      err_count = err_count + 1;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input [5:0] a, input [31:0] d);
    @(posedge core_clk_i);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge core_clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
  endtask
  task rd(input [5:0] a, output [31:0] d);
    @(posedge core_clk_i);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge core_clk_i);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata; rr = rresp; rready <= 1'b0;
  endtask
  task poll(input integer b, input reg v);
    integer n;
    for (n = 0; n < 200; n = n + 1) begin
      rd(A_ST, st);
      if (st[b] === v) break;
    end
    cmp(v, st[b], "status poll");
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Each ramp step while locked equals the programmed rate, except the last one
  always @(posedge core_clk_i) begin
    prev <= speed_cmd;
    if (ab === 1'b1 && atclr === 1'b1) ab_seen <= 1'b1;
    if (locked === 1'b1 && prev > speed_cmd && speed_cmd != 16'h0) cmp(32'h100, prev - speed_cmd, "ramp step");
  end
  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    reg [31:0] ev [0:4];
    reg [5:0] av [0:4];
    ev[0] = `CTRL_RST; ev[1] = 32'h1; ev[2] = 32'h1; ev[3] = 32'h0; ev[4] = 32'h0;
    av[0] = A_CT; av[1] = A_DC; av[2] = A_JK; av[3] = A_ST; av[4] = A_IM;
    for (k = 0; k < 5; k = k + 1) begin
      rd(av[k], st);
      cmp(ev[k], st, "reset value");
    end
    rd(6'h1c, st);
    cmp({30'h0, `RESP_SLVERR}, {30'h0, rr}, "unmapped resp");
    $display("test regs done");
  endtask
  task t_stop;
    vel_start <= 1'b1;
    @(posedge core_clk_i) vel_start <= 1'b0;
    repeat (20) @(posedge core_clk_i);
    wr(A_DC, 32'h100);
    wr(A_CT, 32'h101);
    poll(0, 1'b1);
    cmp(0, st[1], "active with first busy");
    poll(1, 1'b1);
    poll(2, 1'b1);
    cmp(3'b111, st[2:0], "done busy active");
    cmp(1, ab_seen, "velocity move aborted");
    cmp(1, st[13:8], "captured axis");
    repeat (40) @(posedge core_clk_i);
    wr(A_CT, 32'h201);
    rd(A_ST, st);
    cmp(6'h27, st[5:0], "held stopping");
    cmp(1, st[13:8], "axis kept without new edge");
    other <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    cmp(1, refused, "other command refused");
    other <= 1'b0;
    rd(A_IS, st);
    cmp(4'h9, st[3:0], "event bits");
    cmp(1, irq, "irq raised");
    wr(A_IS, 32'hf);
    rd(A_IS, st);
    cmp(0, st[3:0], "event bits cleared");
    repeat (3) @(posedge core_clk_i);
    cmp(0, irq, "irq cleared");
    wr(A_CT, 32'h100);
    poll(0, 1'b0);
    cmp(0, st[2:0], "done busy active drop together");
    repeat (10) @(posedge core_clk_i);
    cmp(0, locked, "axis free");
    $display("test stop done");
  endtask
  task t_early;
    wr(A_IM, 32'h0);
    wr(A_CT, 32'h101);
    poll(0, 1'b1);
    wr(A_CT, 32'h100);
    poll(2, 1'b1);
    cmp(3'b111, st[2:0], "done with busy active");
    poll(0, 1'b0);
    cmp(0, st[2:0], "all clear one period later");
    rd(A_IS, st);
    cmp(3'b001, st[2:0], "done after early release");
    cmp(0, irq, "masked irq");
    wr(A_IS, 32'hf);
    wr(A_IM, 32'hf);
    $display("test early release done");
  endtask
  task t_super;
    wr(A_CT, 32'h101);
    poll(1, 1'b1);
    later <= 1'b1;
    poll(3, 1'b1);
    cmp(0, st[1:0], "busy active dropped");
    later <= 1'b0;
    repeat (20) @(posedge core_clk_i);
    rd(A_ST, st);
    cmp(1, st[3], "flag holds with trigger");
    wr(A_CT, 32'h100);
    poll(3, 1'b0);
    cmp(0, st[5:0], "all low");
    wr(A_CT, 32'h101);
    poll(0, 1'b1);
    wr(A_CT, 32'h100);
    later <= 1'b1;
    poll(3, 1'b1);
    cmp(0, st[2:0], "aborted after early release");
    later <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    rd(A_ST, st);
    cmp(0, st[3], "flag one period only");
    wr(A_IS, 32'hf);
    $display("test supersede done");
  endtask
  task t_fault(input integer f);
    reg [15:0] code [0:5];
    code[0] = `FC_BAD_AXIS; code[1] = `FC_BAD_AXIS; code[2] = `FC_BAD_DECEL;
    code[3] = `FC_BAD_JERK; code[4] = `FC_ALARM; code[5] = `FC_OFFLINE;
    wr(A_DC, (f == 2) ? 32'h0 : 32'h100);
    wr(A_JK, (f == 3) ? 32'h0 : 32'h1);
    wr(A_CT, (f == 0) ? 32'h1 : (f == 1) ? 32'h2101 : 32'h101);
    if (f > 3) begin
      poll(0, 1'b1);
      if (f == 4) alarm <= 1'b1;
      else online <= 1'b0;
    end
    poll(4, 1'b1);
    cmp(code[f], st[31:16], "fault code");
    cmp(0, st[1:0], "busy active after fault");
    alarm <= 1'b0;
    online <= 1'b1;
    wr(A_CT, 32'h100);
    poll(4, 1'b0);
    wr(A_IS, 32'hf);
    $display("test fault %0d done", f);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    t_regs;
    wr(A_IM, 32'hf);
    t_stop;
    t_early;
    t_super;
    for (k = 0; k < 6; k = k + 1) t_fault(k);
    complete_run;
  end
  initial begin
    #4000000;
    err_count = err_count + 1;
    complete_run;
  end
endmodule
